// [common/bws_pkg.sv]
// Notes on behaviour
// - Each block element reads memory at the source pointer and writes it to the I/O port held in the port register.
// - Every I/O write carries a full 16-bit port address whatever the addressing configuration.
// - Descending block forms lower the source pointer by 1 per byte or 2 per word after each element.
// - Ascending block forms raise the source pointer by 1 per byte or 2 per word after each element.
// - The counter drops by one per element and repeating forms go on until the decremented counter is zero.
// - Single-step block forms set overflow when the decremented counter is zero and clear it otherwise.
// - A repeating block write takes 11 cycles plus 10 per element.
// - Repeating forms take interrupts between elements and hand back the instruction's start address.
// - Each interrupt taken inside a repeating block write adds 7 cycles.
// - Every I/O write form runs only in the privileged state.
// - The single port write sends the register value, taking 10 cycles indirect or 12 direct, flags untouched.
package bws_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned IO_ADDR_W = 16;
  localparam int unsigned FIFO_DEPTH = 32;

  localparam logic [3:0] SETUP_CYC = 4'hB;
  localparam logic [3:0] ELEM_CYC = 4'hA;
  localparam logic [3:0] INTR_CYC = 4'h7;
  localparam logic [3:0] OUT_IR_CYC = 4'hA;
  localparam logic [3:0] OUT_DA_CYC = 4'hC;

  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  typedef enum logic [2:0] {
    OP_PORT_WRITE = 3'h0,
    OP_PORT_WRITE_DESCENDING_STEP = 3'h1,
    OP_PORT_WRITE_ASCENDING_STEP = 3'h2,
    OP_PORT_WRITE_DESCENDING_REPEAT = 3'h3,
    OP_PORT_WRITE_ASCENDING_REPEAT = 3'h4
  } bws_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_XFER = 3'h3,
    ST_INTR = 3'h2,
    ST_SINGLE = 3'h4
  } bws_state_type;

  typedef struct packed {
    bws_op_type op;
    logic is_byte;
    logic direct;
    logic [15:0] src_ptr;
    logic [IO_ADDR_W-1:0] port_addr;
    logic [15:0] count;
    logic [DATA_W-1:0] reg_data;
    logic [15:0] pc;
  } bws_cmd_type;

  typedef struct packed {
    logic [15:0] src_ptr;
    logic [15:0] count;
    logic v_flag;
    logic v_upd;
    logic suspended;
  } bws_res_type;

  typedef struct packed {
    logic [IO_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic is_byte;
  } bws_io_type;

  function automatic logic bws_is_repeat(input bws_op_type op);
    return (op == OP_PORT_WRITE_DESCENDING_REPEAT) || (op == OP_PORT_WRITE_ASCENDING_REPEAT);
  endfunction : bws_is_repeat

  function automatic logic bws_is_desc(input bws_op_type op);
    return (op == OP_PORT_WRITE_DESCENDING_STEP) || (op == OP_PORT_WRITE_DESCENDING_REPEAT);
  endfunction : bws_is_desc

  function automatic logic [15:0] bws_step(input logic is_byte);
    return is_byte ? STEP_BYTE : STEP_WORD;
  endfunction : bws_step

endpackage : bws_pkg

// [verilog/bws_fifo.sv]
`timescale 1ns/100ps
module bws_fifo
  import bws_pkg::*;
#(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;

  assign out_valid = (wr_r != rd_r);
  assign in_ready = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
  assign out_data = mem_r[rd_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

endmodule : bws_fifo

// [verilog/bws_block_io_write_sequencer.sv]
`timescale 1ns/100ps
module bws_block_io_write_sequencer
  import bws_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // instruction issue
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bws_cmd_type cmd,
  input wire logic privileged,
  // completion
  output logic done,
  output bws_res_type res,
  output logic priv_fault,
  // interrupt handling
  input wire logic irq_req,
  output logic irq_ack,
  output logic [15:0] resume_pc,
  // memory read
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_rdata,
  // i/o write
  output logic io_valid,
  input wire logic io_ready,
  output logic [IO_ADDR_W-1:0] io_addr,
  output logic [DATA_W-1:0] io_data,
  output logic io_byte
);
  logic rst_meta_r, rst_sync_n_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  bws_state_type st_r, st_nxt;
  logic [3:0] tick_r, tick_nxt;
  logic [15:0] ptr_r, ptr_nxt, cnt_r, cnt_nxt, pc_r, pc_nxt, rpc_r, rpc_nxt, cnt_dec;
  logic [IO_ADDR_W-1:0] port_r, port_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  bws_op_type op_r, op_nxt;
  logic byte_r, byte_nxt, direct_r, direct_nxt, pend_r, pend_nxt;
  logic done_r, done_nxt, fault_r, fault_nxt, ack_r, ack_nxt;
  bws_res_type res_r, res_nxt;
  logic fifo_in_ready, fifo_push, elem_end;
  bws_io_type fifo_in_data, fifo_out_data;

  assign cmd_ready = (st_r == ST_IDLE);
  assign fifo_push = pend_r && fifo_in_ready;
  assign fifo_in_data = '{addr: port_r, data: data_r, is_byte: byte_r};
  assign mem_rd = (st_r == ST_XFER) && (tick_r == 4'h0);
  assign mem_addr = ptr_r;
  assign cnt_dec = cnt_r - 16'h0001;
  assign elem_end = (st_r == ST_XFER) && (tick_r == ELEM_CYC - 4'h1) && !(pend_r && !fifo_in_ready);
  assign done = done_r;
  assign res = res_r;
  assign priv_fault = fault_r;
  assign irq_ack = ack_r;
  assign resume_pc = rpc_r;

  always_comb begin
    st_nxt = st_r;
    tick_nxt = tick_r;
    ptr_nxt = ptr_r;
    cnt_nxt = cnt_r;
    port_nxt = port_r;
    data_nxt = data_r;
    byte_nxt = byte_r;
    op_nxt = op_r;
    pc_nxt = pc_r;
    direct_nxt = direct_r;
    pend_nxt = fifo_push ? 1'b0 : pend_r;
    done_nxt = 1'b0;
    fault_nxt = 1'b0;
    ack_nxt = 1'b0;
    res_nxt = res_r;
    rpc_nxt = rpc_r;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd_valid) begin
          if (!privileged) begin
            fault_nxt = 1'b1;
          end else begin
            op_nxt = cmd.op;
            byte_nxt = cmd.is_byte;
            direct_nxt = cmd.direct;
            ptr_nxt = cmd.src_ptr;
            cnt_nxt = cmd.count;
            port_nxt = cmd.port_addr;
            pc_nxt = cmd.pc;
            tick_nxt = 4'h0;
            if (cmd.op == OP_PORT_WRITE) begin
              data_nxt = cmd.reg_data;
              pend_nxt = 1'b1;
              st_nxt = ST_SINGLE;
            end else begin
              st_nxt = ST_SETUP;
            end
          end
        end
      end
      ST_SETUP: begin
        if (tick_r == SETUP_CYC - 4'h1) begin
          tick_nxt = 4'h0;
          st_nxt = ST_XFER;
        end else begin
          tick_nxt = tick_r + 4'h1;
        end
      end
      ST_XFER: begin
        if (tick_r == 4'h1) begin
          data_nxt = byte_r ? {8'h00, mem_rdata[7:0]} : mem_rdata;
          pend_nxt = 1'b1;
        end
        if (elem_end) begin
          ptr_nxt = bws_is_desc(op_r) ? ptr_r - bws_step(byte_r) : ptr_r + bws_step(byte_r);
          cnt_nxt = cnt_dec;
          tick_nxt = 4'h0;
          if (bws_is_repeat(op_r) && (cnt_dec != 16'h0000)) begin
            if (irq_req) begin
              st_nxt = ST_INTR;
              ack_nxt = 1'b1;
              rpc_nxt = pc_r;
            end
          end else begin
            st_nxt = ST_IDLE;
            done_nxt = 1'b1;
            res_nxt = '{src_ptr: ptr_nxt, count: cnt_dec, v_flag: (cnt_dec == 16'h0000),
                        v_upd: 1'b1, suspended: 1'b0};
          end
        end else if (tick_r != ELEM_CYC - 4'h1) begin
          tick_nxt = tick_r + 4'h1;
        end
      end
      ST_INTR: begin
        if (tick_r == INTR_CYC - 4'h1) begin
          st_nxt = ST_IDLE;
          done_nxt = 1'b1;
          res_nxt = '{src_ptr: ptr_r, count: cnt_r, v_flag: 1'b0, v_upd: 1'b0, suspended: 1'b1};
        end else begin
          tick_nxt = tick_r + 4'h1;
        end
      end
      ST_SINGLE: begin
        if ((tick_r == 4'h0) && pend_r && !fifo_in_ready) begin
          tick_nxt = tick_r;
        end else if (tick_r == (direct_r ? OUT_DA_CYC : OUT_IR_CYC) - 4'h1) begin
          st_nxt = ST_IDLE;
          done_nxt = 1'b1;
          res_nxt = '{src_ptr: ptr_r, count: cnt_r, v_flag: 1'b0, v_upd: 1'b0, suspended: 1'b0};
        end else begin
          tick_nxt = tick_r + 4'h1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      st_r <= ST_IDLE;
      tick_r <= 4'h0;
      ptr_r <= 16'h0000;
      cnt_r <= 16'h0000;
      port_r <= '0;
      data_r <= '0;
      byte_r <= 1'b0;
      op_r <= OP_PORT_WRITE;
      pc_r <= 16'h0000;
      direct_r <= 1'b0;
      pend_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      ack_r <= 1'b0;
      res_r <= '0;
      rpc_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      ptr_r <= ptr_nxt;
      cnt_r <= cnt_nxt;
      port_r <= port_nxt;
      data_r <= data_nxt;
      byte_r <= byte_nxt;
      op_r <= op_nxt;
      pc_r <= pc_nxt;
      direct_r <= direct_nxt;
      pend_r <= pend_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      ack_r <= ack_nxt;
      res_r <= res_nxt;
      rpc_r <= rpc_nxt;
    end
  end

  bws_fifo #(
    .WIDTH($bits(bws_io_type)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_n_r),
    .in_valid(pend_r),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(io_valid),
    .out_ready(io_ready),
    .out_data(fifo_out_data)
  );

  assign io_addr = fifo_out_data.addr;
  assign io_data = fifo_out_data.data;
  assign io_byte = fifo_out_data.is_byte;

  // checks
  logic accept;
  assign accept = cmd_valid && cmd_ready && privileged;

  sequence s_setup;
    (st_r == ST_SETUP) ##10 (st_r == ST_SETUP) ##1 (st_r == ST_XFER);
  endsequence

  sequence s_intr;
    (st_r == ST_INTR) ##6 (st_r == ST_INTR) ##1 (done_r && res_r.suspended);
  endsequence

  property p_priv;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (cmd_valid && cmd_ready && !privileged) |=> (fault_r && st_r == ST_IDLE);
  endproperty
  a_priv: assert property (p_priv) else $error("unprivileged write was executed");

  property p_port_hold;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (st_r != ST_IDLE && $past(st_r) != ST_IDLE) |-> $stable(port_r);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port register changed mid transfer");

  property p_push;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (st_r == ST_XFER && tick_r == 4'h1) |=> (pend_r && data_r[7:0] == $past(mem_rdata[7:0]));
  endproperty
  a_push: assert property (p_push) else $error("memory element not queued for the port");

  property p_io_addr;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      accept |=> (port_r == $past(cmd.port_addr));
  endproperty
  a_io_addr: assert property (p_io_addr) else $error("port address not kept at 16 bits");

  property p_desc;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (elem_end && bws_is_desc(op_r)) |=> (ptr_r == $past(ptr_r) - (byte_r ? STEP_BYTE : STEP_WORD));
  endproperty
  a_desc: assert property (p_desc) else $error("descending pointer step wrong");

  property p_asc;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (elem_end && !bws_is_desc(op_r)) |=> (ptr_r == $past(ptr_r) + (byte_r ? STEP_BYTE : STEP_WORD));
  endproperty
  a_asc: assert property (p_asc) else $error("ascending pointer step wrong");

  property p_count;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (elem_end && bws_is_repeat(op_r) && cnt_r != 16'h0001 && !irq_req) |=>
        (cnt_r == $past(cnt_r) - 16'h0001 && st_r == ST_XFER && tick_r == 4'h0);
  endproperty
  a_count: assert property (p_count) else $error("repeat did not continue with decremented counter");

  property p_vflag;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (elem_end && !bws_is_repeat(op_r)) |=> (done_r && res_r.v_upd && res_r.v_flag == (res_r.count == 16'h0000));
  endproperty
  a_vflag: assert property (p_vflag) else $error("overflow flag wrong after single step");

  property p_setup;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (accept && cmd.op != OP_PORT_WRITE) |=> s_setup;
  endproperty
  a_setup: assert property (p_setup) else $error("block setup not eleven cycles");

  property p_resume;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      irq_ack |-> (resume_pc == pc_r && $past(st_r) == ST_XFER && cnt_r != 16'h0000);
  endproperty
  a_resume: assert property (p_resume) else $error("resume address not instruction start");

  property p_intr;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      irq_ack |-> s_intr;
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt overhead not seven cycles");

  property p_single;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (accept && cmd.op == OP_PORT_WRITE && !cmd.direct) ##1 fifo_in_ready |-> ##10 (done_r && !res_r.v_upd);
  endproperty
  a_single: assert property (p_single) else $error("indirect port write not ten cycles");

  property p_single_da;
    @(posedge clk_sys) disable iff (!rst_sync_n_r)
      (accept && cmd.op == OP_PORT_WRITE && cmd.direct) ##1 fifo_in_ready |-> ##12 done_r;
  endproperty
  a_single_da: assert property (p_single_da) else $error("direct port write not twelve cycles");

endmodule : bws_block_io_write_sequencer

// [tb/bws_io_partner.sv]
`timescale 1ns/100ps
module bws_io_partner
  import bws_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // memory side
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [DATA_W-1:0] mem_rdata,
  // port side
  input wire logic io_valid,
  output logic io_ready,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic [DATA_W-1:0] io_data,
  input wire logic io_byte,
  input wire logic stall
);
  bws_io_type seen_q[$];

  assign io_ready = !stall;
  initial mem_rdata = 16'h0000;

  always @(posedge clk_sys) begin
    // stale read data keeps toggling so nothing leans on it
    if (mem_rd) begin
      mem_rdata <= mem_addr ^ 16'hC35A;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (io_valid && io_ready) begin
      seen_q.push_back('{io_addr, io_data, io_byte});
    end
  end
endmodule : bws_io_partner

// [tb/tb.sv]
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb;
  import bws_pkg::*;
  logic clk_sys, rst_n, cmd_valid, cmd_ready, privileged, done, priv_fault, irq_req, irq_ack;
  logic mem_rd, io_valid, io_ready, io_byte, stall, pf;
  logic [15:0] resume_pc, mem_addr, mem_rdata, io_addr, io_data, k, a;
  bws_cmd_type cmd, c;
  bws_res_type res;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int acks = 0;
  int n;

  bws_block_io_write_sequencer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .privileged(privileged), .done(done), .res(res),
    .priv_fault(priv_fault), .irq_req(irq_req), .irq_ack(irq_ack), .resume_pc(resume_pc),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .io_valid(io_valid),
    .io_ready(io_ready), .io_addr(io_addr), .io_data(io_data), .io_byte(io_byte));

  bws_io_partner mdl_u (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .io_valid(io_valid), .io_ready(io_ready), .io_addr(io_addr), .io_data(io_data), .io_byte(io_byte),
    .stall(stall));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (irq_ack === 1'b1) acks++;
    if (cyc == 6000) begin
      fails++;
      finish_test();
    end
  end

  function automatic bws_cmd_type mk(bws_op_type op, logic b, logic d, logic [15:0] s, p, cnt, pc);
    mk = '{op, b, d, s, p, cnt, 16'h5252, pc};
  endfunction : mk

  task automatic finish_test();
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // offer one instruction, count edges until done or refusal
  task automatic run(input bws_cmd_type cc, input logic pr);
    cmd = cc;
    privileged = pr;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    n = 0;
    // a refusal pulses for one cycle right after the offer
    pf = (priv_fault === 1'b1);
    while (n < 2000 && !pf && done !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask : run

  task automatic chk_io(input bws_cmd_type cc, input int cnt);
    bws_io_type e;
    logic [15:0] st;
    st = cc.is_byte ? 16'h0001 : 16'h0002;
    `CHK(mdl_u.seen_q.size(), cnt)
    for (int i = 0; i <= cnt; i++) begin
      a = (cc.op inside {OP_PORT_WRITE_DESCENDING_STEP, OP_PORT_WRITE_DESCENDING_REPEAT}) ?
          cc.src_ptr - st * 16'(i) : cc.src_ptr + st * 16'(i);
      if (i < cnt && i < mdl_u.seen_q.size()) begin
        e = mdl_u.seen_q[i];
        `CHK(e.addr, cc.port_addr)
        `CHK(e.data, cc.is_byte ? {8'h00, a[7:0] ^ 8'h5A} : a ^ 16'hC35A)
        `CHK(e.is_byte, cc.is_byte)
      end
    end
    mdl_u.seen_q.delete();
  endtask : chk_io

  task automatic pw(input logic d);
    c = mk(OP_PORT_WRITE, 1'b0, d, 16'h0000, 16'hFF01, 16'h0000, 16'h0100);
    run(c, 1'b1);
    `CHK(n, d ? 12 : 10)
    `CHK(res.v_upd, 1'b0)
    `CHK(mdl_u.seen_q.size(), 1)
    `CHK(mdl_u.seen_q[0], bws_io_type'({16'hFF01, 16'h5252, 1'b0}))
    mdl_u.seen_q.delete();
  endtask : pw

  task automatic blk(input bws_op_type op, input logic b, input logic [15:0] s, cnt);
    logic rep;
    c = mk(op, b, 1'b0, s, 16'h0FFF, cnt, 16'h0200);
    rep = op inside {OP_PORT_WRITE_DESCENDING_REPEAT, OP_PORT_WRITE_ASCENDING_REPEAT};
    run(c, 1'b1);
    if (rep) `CHK(n, 11 + 10 * cnt)
    `CHK(res.count, rep ? 16'h0000 : cnt - 16'h0001)
    `CHK(res.v_flag, rep | (cnt == 16'h0001))
    `CHK(res.v_upd, 1'b1)
    `CHK(res.suspended, 1'b0)
    chk_io(c, rep ? int'(cnt) : 1);
    `CHK(res.src_ptr, a)
  endtask : blk

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    privileged = 1'b1;
    irq_req = 1'b0;
    stall = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    pw(1'b0);
    pw(1'b1);
    // software keeps counts within the legal element range
    blk(OP_PORT_WRITE_ASCENDING_REPEAT, 1'b1, 16'h1000, 16'h0003);
    blk(OP_PORT_WRITE_DESCENDING_REPEAT, 1'b0, 16'h0002, 16'h0003);
    blk(OP_PORT_WRITE_ASCENDING_REPEAT, 1'b0, 16'hFFFE, 16'h0001);
    blk(OP_PORT_WRITE_ASCENDING_STEP, 1'b0, 16'h4000, 16'h0001);
    blk(OP_PORT_WRITE_ASCENDING_STEP, 1'b1, 16'h4000, 16'h0002);
    blk(OP_PORT_WRITE_DESCENDING_STEP, 1'b1, 16'h4001, 16'h0005);
    blk(OP_PORT_WRITE_DESCENDING_STEP, 1'b0, 16'h4002, 16'h0001);
    for (int j = 0; j < 2; j++) begin
      c = mk(j ? OP_PORT_WRITE : OP_PORT_WRITE_ASCENDING_REPEAT, 1'b0, 1'b0, 16'h5000, 16'h0001,
             16'h0002, 16'h0000);
      run(c, 1'b0);
      `CHK(pf, 1'b1)
      `CHK(n, 0)
      repeat (30) @(posedge clk_sys);
      #1 `CHK(mdl_u.seen_q.size(), 0)
    end
    // interrupt pending from the start, then resume with updated registers
    irq_req = 1'b1;
    c = mk(OP_PORT_WRITE_ASCENDING_REPEAT, 1'b0, 1'b0, 16'h2000, 16'h0FFF, 16'h0004, 16'h0345);
    run(c, 1'b1);
    irq_req = 1'b0;
    `CHK(res.count, 16'h0003)
    k = 16'h0004 - res.count;
    `CHK(res.suspended, 1'b1)
    `CHK(resume_pc, 16'h0345)
    `CHK(acks, 1)
    `CHK(n, 18 + 10 * k)
    `CHK(res.src_ptr, 16'h2000 + 16'h0002 * k)
    chk_io(c, int'(k));
    c = mk(OP_PORT_WRITE_ASCENDING_REPEAT, 1'b0, 1'b0, res.src_ptr, 16'h0FFF, res.count, 16'h0345);
    blk(c.op, 1'b0, c.src_ptr, c.count);
    `CHK(res.src_ptr, 16'h2008)
    // port side stalls until the buffer is full, then drains
    stall = 1'b1;
    c = mk(OP_PORT_WRITE_ASCENDING_REPEAT, 1'b1, 1'b0, 16'h3000, 16'h0042, 16'h0028, 16'h0000);
    fork
      run(c, 1'b1);
      begin
        repeat (400) @(posedge clk_sys);
        #1 `CHK(io_valid, 1'b1)
        `CHK(cmd_ready, 1'b0)
        `CHK(mem_addr, 16'h3000 + 16'(FIFO_DEPTH))
        stall = 1'b0;
      end
    join
    `CHK(res.src_ptr, 16'h3028)
    repeat (40) @(posedge clk_sys);
    #1 `CHK(io_valid, 1'b0)
    chk_io(c, 40);
    finish_test();
  end
endmodule : tb
